// ==== gwl_host.sv ====
// host model driving the three-wire gain link
module gwl_host (
	output logic sclk,
	output logic load_enable_n,
	output logic serial_gain_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// link clock rests low between frames unless idle_clocks runs it
	initial begin
		sclk = 1'b0;
		load_enable_n = 1'b1;
		serial_gain_in = 1'b0;
	end
	task automatic send(input logic [7:0] w, input int n);
		load_enable_n = 1'b0;
		// odd lead time keeps link edges off the system clock edges
		#37;
		for (int i = n - 1; i >= 0; i--) begin
			serial_gain_in = w[i];
			#40 sclk = 1'b1;
			#40 sclk = 1'b0;
		end
		// released data line shows the inverse, never a stale bit
		serial_gain_in = ~serial_gain_in;
		#40 load_enable_n = 1'b1;
	endtask : send
	// serial clocks with load enable high, which the shifter must ignore
	task automatic idle_clocks(input int n);
		for (int i = 0; i < n; i++) begin
			serial_gain_in = ~serial_gain_in;
			#40 sclk = 1'b1;
			#40 sclk = 1'b0;
		end
	endtask : idle_clocks
endmodule : gwl_host

// ==== gwl_link_if.sv ====
// signals between the link-side shifter and the core of the gain loader
interface gwl_link_if;
	logic load_enable_n;
	logic serial_gain_in;
	logic [5:0] shift_word;

	modport shifter (
		input load_enable_n,
		input serial_gain_in,
		output shift_word
	);
	modport core (
		output load_enable_n,
		output serial_gain_in,
		input shift_word
	);
endinterface : gwl_link_if

// ==== gwl_loader.sv ====
// serial gain-word loader: link shifter, load capture, code clamp and power state
//
// Operation
// - gain code held in six-bit shift register, most significant bit first
// - shift serial data on serial clock rise while load enable low
// - eight-bit words keep six low bits; leading two bits fall away
// - codes one through sixty are valid distinct gain steps
// - codes 61 to 63 apply code sixty, maximum gain
// - gain rises one dB per code, -25.5 dB to +33.5 dB
// - applied gain starts at code one after power-up
// - transmit enable low gives between-burst state, high transmits
// - sleep input low puts device into lowest-power sleep
// - load enable rise applies shifted code; fall keeps gain, reopens shifting
// - sleep input high returns device to operating state
module gwl_loader
	import gwl_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic SCLK,
	input wire logic LOAD_ENABLE_N,
	input wire logic SERIAL_GAIN_IN,
	input wire logic BURST_TRANSMIT_ON,
	input wire logic SLEEP_N,
	output logic [5:0] GAIN_CODE,
	output logic signed [7:0] GAIN_HALF_DB,
	output logic GAIN_UPDATED,
	output logic AMP_TRANSMIT,
	output logic AMP_SLEEP,
	output logic [2:0] POWER_STATE
);
	gwl_link_if link ();

	logic [GWL_CODE_W:0] link_sync;
	logic [1:0] ctrl_sync;
	logic tx_on_s;
	logic sleep_req_s;
	logic load_enable_n_s;
	logic [GWL_CODE_W-1:0] word_s;
	logic load_enable_n_prev_q;
	logic load_rise;
	logic [GWL_CODE_W-1:0] code_clamped;
	logic [GWL_CODE_W-1:0] gain_code_q;
	logic signed [GWL_GAIN_W-1:0] gain_half_db_d;
	logic signed [GWL_GAIN_W-1:0] gain_half_db_q;
	logic gain_updated_q;
	gwl_power_type power_d;
	gwl_power_type power_q;

	////////////////////////////////////////////////////////////////////////////////
	// link domain

	assign link.load_enable_n = LOAD_ENABLE_N;
	assign link.serial_gain_in = SERIAL_GAIN_IN;

	gwl_shift u_shift (
		.sclk(SCLK),
		.link(link.shifter)
	);

	////////////////////////////////////////////////////////////////////////////////
	// crossings into the CLOCK domain

	// word and enable travel together; the word is frozen while enable is high,
	// so it is settled by the time the enable rise emerges from the synchroniser;
	// the enable crosses inverted so that the cleared synchroniser reads as idle-high
	gwl_sync #(
		.WIDTH(GWL_CODE_W + 1)
	) u_sync_link (
		.clk(CLOCK),
		.rst(RST),
		.async_in({~LOAD_ENABLE_N, link.shift_word}),
		.sync_out(link_sync)
	);

	// transmit and sleep are asynchronous pins; two stages keep metastability out;
	// sleep crosses as a request so that a cleared synchroniser means awake
	gwl_sync #(
		.WIDTH(2)
	) u_sync_ctrl (
		.clk(CLOCK),
		.rst(RST),
		.async_in({BURST_TRANSMIT_ON, ~SLEEP_N}),
		.sync_out(ctrl_sync)
	);

	assign load_enable_n_s = ~link_sync[GWL_CODE_W];
	assign word_s = link_sync[GWL_CODE_W-1:0];
	assign tx_on_s = ctrl_sync[1];
	assign sleep_req_s = ctrl_sync[0];

	////////////////////////////////////////////////////////////////////////////////
	// load capture

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			load_enable_n_prev_q <= 1'b1;
		end else begin
			load_enable_n_prev_q <= load_enable_n_s;
		end
	end

	// both stages clear to the idle-high level, so a pin standing high across
	// reset is never taken for a load of a stale or never-shifted word
	assign load_rise = load_enable_n_s & ~load_enable_n_prev_q;

	always_comb begin
		if (word_s == GWL_CODE_ZERO) begin
			code_clamped = GWL_CODE_MIN;
		end else if (word_s > GWL_CODE_MAX) begin
			code_clamped = GWL_CODE_MAX;
		end else begin
			code_clamped = word_s;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			gain_code_q <= GWL_CODE_RESET;
		end else if (load_rise) begin
			gain_code_q <= code_clamped;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			gain_updated_q <= 1'b0;
		end else begin
			gain_updated_q <= load_rise;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// gain in half-dB units: 2*code - 53

	always_comb begin
		gain_half_db_d = GWL_HALF_DB_AT_ZERO
			+ signed'({1'b0, gain_code_q, 1'b0});
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			gain_half_db_q <= GWL_HALF_DB_AT_ZERO + signed'({1'b0, GWL_CODE_RESET, 1'b0});
		end else begin
			gain_half_db_q <= gain_half_db_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// power state: sleep outranks transmit enable

	always_comb begin
		power_d = power_q;
		unique case (power_q)
			GWL_PWR_SLEEP: begin
				if (!sleep_req_s) begin
					power_d = tx_on_s ? GWL_PWR_TRANSMIT : GWL_PWR_IDLE;
				end
			end
			GWL_PWR_IDLE: begin
				if (sleep_req_s) begin
					power_d = GWL_PWR_SLEEP;
				end else if (tx_on_s) begin
					power_d = GWL_PWR_TRANSMIT;
				end
			end
			GWL_PWR_TRANSMIT: begin
				if (sleep_req_s) begin
					power_d = GWL_PWR_SLEEP;
				end else if (!tx_on_s) begin
					power_d = GWL_PWR_IDLE;
				end
			end
			// a corrupted one-hot code falls back to the quiet between-burst state
			default: begin
				power_d = GWL_PWR_IDLE;
			end
		endcase
	end

	// reset lands in between-burst, the safe state while the host programs the gain
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			power_q <= GWL_PWR_IDLE;
		end else begin
			power_q <= power_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all from flip-flops

	assign GAIN_CODE = gain_code_q;
	assign GAIN_HALF_DB = gain_half_db_q;
	assign GAIN_UPDATED = gain_updated_q;
	assign POWER_STATE = power_q;
	assign AMP_TRANSMIT = power_q[2];
	assign AMP_SLEEP = power_q[0];
endmodule : gwl_loader

// ==== gwl_loader_asserts.sv ====
// assertions on the ports of the serial gain loader
module gwl_loader_asserts (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic LOAD_ENABLE_N,
	input wire logic BURST_TRANSMIT_ON,
	input wire logic SLEEP_N,
	input wire logic [5:0] GAIN_CODE,
	input wire logic signed [7:0] GAIN_HALF_DB,
	input wire logic GAIN_UPDATED,
	input wire logic AMP_TRANSMIT,
	input wire logic AMP_SLEEP,
	input wire logic [2:0] POWER_STATE
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	property p_range; GAIN_CODE >= 6'h01 && GAIN_CODE <= 6'h3c; endproperty
	property p_db; GAIN_UPDATED |=> GAIN_HALF_DB == 8'({GAIN_CODE, 1'b0} - 8'h35); endproperty
	property p_chg; $changed(GAIN_CODE) |-> GAIN_UPDATED; endproperty
	property p_pulse; GAIN_UPDATED |=> !GAIN_UPDATED; endproperty
	property p_load; $rose(LOAD_ENABLE_N) |-> ##[3:5] GAIN_UPDATED; endproperty
	property p_sleep; !SLEEP_N [*4] |-> AMP_SLEEP && POWER_STATE == 3'h1; endproperty
	property p_tx; (SLEEP_N && BURST_TRANSMIT_ON) [*4] |-> AMP_TRANSMIT && !AMP_SLEEP; endproperty
	property p_idle; (SLEEP_N && !BURST_TRANSMIT_ON) [*4] |-> POWER_STATE == 3'h2; endproperty
	property p_rst_pwr; $fell(RST) |-> POWER_STATE == 3'h2 ##1 POWER_STATE == 3'h2 ##1 POWER_STATE == 3'h2; endproperty
	property p_rst_load; $fell(RST) && LOAD_ENABLE_N |-> !GAIN_UPDATED [*6]; endproperty
	a_range: assert property (p_range) else $error("code range");
	a_db: assert property (p_db) else $error("gain value");
	a_chg: assert property (p_chg) else $error("code moved");
	a_pulse: assert property (p_pulse) else $error("pulse width");
	a_load: assert property (p_load) else $error("no load");
	a_sleep: assert property (p_sleep) else $error("no sleep");
	a_tx: assert property (p_tx) else $error("no transmit");
	a_idle: assert property (p_idle) else $error("not idle");
	a_rst_pwr: assert property (p_rst_pwr) else $error("power state after reset");
	a_rst_load: assert property (p_rst_load) else $error("load after reset");
	c_load: cover property (GAIN_UPDATED);
	c_sleep: cover property (AMP_SLEEP);
	c_tx: cover property (AMP_TRANSMIT);
	c_rst: cover property ($fell(RST));
endmodule : gwl_loader_asserts
bind gwl_loader gwl_loader_asserts i_chk (.CLOCK(CLOCK), .RST(RST), .LOAD_ENABLE_N(LOAD_ENABLE_N),
	.BURST_TRANSMIT_ON(BURST_TRANSMIT_ON), .SLEEP_N(SLEEP_N), .GAIN_CODE(GAIN_CODE),
	.GAIN_HALF_DB(GAIN_HALF_DB), .GAIN_UPDATED(GAIN_UPDATED), .AMP_TRANSMIT(AMP_TRANSMIT),
	.AMP_SLEEP(AMP_SLEEP), .POWER_STATE(POWER_STATE));

// ==== gwl_pkg.sv ====
// constants and types shared by the serial gain loader
package gwl_pkg;
	localparam int GWL_CODE_W = 6;
	localparam logic [5:0] GWL_CODE_MIN = 6'h01;
	localparam logic [5:0] GWL_CODE_MAX = 6'h3c;
	localparam logic [5:0] GWL_CODE_RESET = 6'h01;
	localparam logic [5:0] GWL_CODE_ZERO = 6'h00;
	// gain reported in half-decibel steps: code 1 is -25.5 dB, one dB per code
	localparam int GWL_GAIN_W = 8;
	localparam logic signed [7:0] GWL_HALF_DB_AT_ZERO = 8'shcb;
	localparam int GWL_HALF_DB_PER_CODE_SHIFT = 1;
	localparam int GWL_SYNC_STAGES = 2;
	localparam logic [2:0] GWL_POWER_RESET = 3'h2;

	typedef enum logic [2:0] {
		GWL_PWR_SLEEP = 3'h1,
		GWL_PWR_IDLE = 3'h2,
		GWL_PWR_TRANSMIT = 3'h4
	} gwl_power_type;
endpackage : gwl_pkg

// ==== gwl_shift.sv ====
// link-side 6-bit shift register clocked by the host serial clock
module gwl_shift
	import gwl_pkg::*;
(
	input wire logic sclk,
	gwl_link_if.shifter link
);
	logic [GWL_CODE_W-1:0] shift_q;

	// no reset: the serial clock may stand still, and only six trailing bits matter
	always_ff @(posedge sclk) begin
		if (!link.load_enable_n) begin
			shift_q <= {shift_q[GWL_CODE_W-2:0], link.serial_gain_in};
		end
	end

	assign link.shift_word = shift_q;
endmodule : gwl_shift

// ==== gwl_sync.sv ====
// two flip-flop synchroniser for a group of quasi-static levels
module gwl_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : gwl_sync

// ==== tb_gwl_loader.sv ====
// self-checking bench for the serial gain loader
module tb_gwl_loader
	import gwl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0, rst = 1'b1, tx = 1'b0, sleep_n = 1'b1, sclk, le_n, sdi;
	logic [5:0] code;
	logic signed [7:0] hdb;
	logic upd, amp_tx, amp_sl;
	logic [2:0] pwr;
	int errors = 0, compares = 0;
	// rows: bit count, shifted word, expected applied code
	logic [19:0] rows [8] = '{20'h84b0b, 20'h63c3c, 20'h63d3c, 20'h63e3c, 20'h63f3c, 20'h60001, 20'h60101, 20'h62a2a};
	gwl_host i_host (.sclk(sclk), .load_enable_n(le_n), .serial_gain_in(sdi));
	gwl_loader i_dut (.CLOCK(clock), .RST(rst), .SCLK(sclk), .LOAD_ENABLE_N(le_n), .SERIAL_GAIN_IN(sdi),
		.BURST_TRANSMIT_ON(tx), .SLEEP_N(sleep_n), .GAIN_CODE(code), .GAIN_HALF_DB(hdb), .GAIN_UPDATED(upd),
		.AMP_TRANSMIT(amp_tx), .AMP_SLEEP(amp_sl), .POWER_STATE(pwr));
	initial begin
		forever #4 clock = ~clock;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic results();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results
	task automatic load(input logic [7:0] w, input int n);
		int k;
		k = 0;
		i_host.send(w, n);
		while (upd !== 1'b1 && k < 20) begin
			@(negedge clock);
			k++;
		end
		if (upd !== 1'b1) begin
			errors++;
			results();
		end
		repeat (2) @(negedge clock);
	endtask : load
	task automatic power(input logic t, input logic s, input logic [2:0] exp);
		tx = t;
		sleep_n = s;
		repeat (4) @(negedge clock);
		check({5'h0, pwr}, {5'h0, exp});
		check({6'h0, amp_sl, amp_tx}, {6'h0, exp[0], exp[2]});
	endtask : power
	initial begin
		repeat (3) @(negedge clock);
		rst = 1'b0;
		@(negedge clock);
		check({2'h0, code}, 8'h01);
		check({5'h0, pwr}, {5'h0, GWL_PWR_IDLE});
		foreach (rows[i]) begin
			load(rows[i][15:8], int'(rows[i][19:16]));
			check({2'h0, code}, rows[i][7:0]);
			check(hdb, 8'(rows[i][7:0] * 2 - 53));
		end
		$display("gain rows done");
		// clocks while load enable is high must leave the held word alone
		i_host.idle_clocks(6);
		load(8'h00, 0);
		check({2'h0, code}, rows[7][7:0]);
		$display("refused clocks done");
		// transmit only after the gain is programmed
		power(1'b1, 1'b1, GWL_PWR_TRANSMIT);
		power(1'b1, 1'b0, GWL_PWR_SLEEP);
		power(1'b0, 1'b1, GWL_PWR_IDLE);
		$display("power pins done");
		rst = 1'b1;
		repeat (3) @(negedge clock);
		rst = 1'b0;
		@(negedge clock);
		check({2'h0, code}, 8'h01);
		check({5'h0, pwr}, {5'h0, GWL_PWR_IDLE});
		// load enable stood high across reset: no load may follow
		repeat (6) @(negedge clock);
		check({2'h0, code}, 8'h01);
		check(hdb, 8'hcd);
		check({7'h0, upd}, 8'h00);
		$display("second reset done");
		results();
	end
endmodule : tb_gwl_loader
